// >>> verif/icfg_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************
// two-wire controller model, link clock
// ************************************
module icfg_ctrl_model (
  output var  logic scl_out,
  output var  logic sda_low_out,
  input  wire logic sda_in
);
  // clock stands still between frames
  localparam realtime HALF = 40.0;
  initial begin
    scl_out     = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic start_frame();
    // quarter periods are two and a half system periods, so shift off the system edges
    #1;
    sda_low_out = 1'b0;
    #(HALF);
    scl_out = 1'b1;
    #(4 * HALF);
    sda_low_out = 1'b1;
    #(4 * HALF);
    scl_out = 1'b0;
  endtask
  task automatic stop_frame();
    #(HALF / 2);
    sda_low_out = 1'b1;
    #(HALF / 2);
    scl_out = 1'b1;
    #(4 * HALF);
    sda_low_out = 1'b0;
    #(4 * HALF);
  endtask
  // data moves only mid-low, sampled mid-high
  task automatic put_bit(input logic b, output logic seen);
    #(HALF / 2);
    sda_low_out = !b;
    #(HALF / 2);
    scl_out = 1'b1;
    #(HALF / 2);
    seen = sda_in;
    #(HALF / 2);
    scl_out = 1'b0;
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(b[i], s);
    put_bit(1'b1, s);
    ack = !s;
  endtask
  task automatic get_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, s);
      b[i] = s;
    end
    put_bit(last, s);
  endtask
endmodule
`default_nettype wire

// >>> verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import icfg_pkg::*;
  localparam logic [6:0] OWN_ADDR = 7'h2A;
  logic           sys_clk_in;
  logic           resetn_in;
  logic           iface_en_in;
  logic [7:0]     cfg_rd_addr_in;
  logic           scl;
  logic           sda_low;
  wire logic      sda;
  logic           sda_out;
  logic           sda_oe_out;
  icfg_wr_t       cfg_wr_out;
  logic [7:0]     cfg_rd_data_out;
  logic           busy_out;
  logic [7:0]     n_wr;
  logic [7:0]     last_wr;
  logic [7:0]     last_dat;
  int             n_mismatch;
  int             num_checks;
  // pull-up: released line reads high
  assign sda = !(sda_low || (sda_oe_out && !sda_out));
  icfg_target #(.TARGET_ADDR(OWN_ADDR), .DEPTH(256)) DUT (
    .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .scl_clk_in(scl), .sda_in(sda),
    .iface_en_in(iface_en_in), .cfg_rd_addr_in(cfg_rd_addr_in), .sda_out(sda_out),
    .sda_oe_out(sda_oe_out), .cfg_wr_out(cfg_wr_out), .cfg_rd_data_out(cfg_rd_data_out),
    .busy_out(busy_out));
  icfg_ctrl_model u_ctrl (.scl_out(scl), .sda_low_out(sda_low), .sda_in(sda));
  initial begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      n_wr     <= 8'h00;
      last_wr  <= 8'h00;
      last_dat <= 8'h00;
    end else if (cfg_wr_out.valid === 1'b1) begin
      n_wr     <= n_wr + 8'h01;
      last_wr  <= cfg_wr_out.addr;
      last_dat <= cfg_wr_out.data;
    end
  end
  // ************************************
  // checking and closing
  // ************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("mismatches %0d checks %0d", n_mismatch, num_checks);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic peek(input logic [7:0] a, input logic [7:0] e);
    @(negedge sys_clk_in) cfg_rd_addr_in = a;
    repeat (2) @(negedge sys_clk_in);
    chk(cfg_rd_data_out, e);
  endtask
  // ************************************
  // scenarios
  // ************************************
  task automatic write_burst();
    logic a;
    u_ctrl.start_frame();
    u_ctrl.send_byte({OWN_ADDR, 1'b0}, a);
    chk({7'h00, a}, 8'h01);
    chk({7'h00, busy_out}, 8'h01);
    u_ctrl.send_byte(8'h40, a);
    chk({7'h00, a}, 8'h01);
    for (int i = 0; i < 3; i++) begin
      u_ctrl.send_byte(8'hA0 + 8'(i), a);
      chk({7'h00, a}, 8'h01);
    end
    u_ctrl.stop_frame();
    chk({7'h00, busy_out}, 8'h00);
    chk(n_wr, 8'h03);
    chk(last_wr, 8'h42);
    chk(last_dat, 8'hA2);
    for (int i = 0; i < 3; i++) peek(8'h40 + 8'(i), 8'hA0 + 8'(i));
  endtask
  task automatic read_burst();
    logic       a;
    logic [7:0] b;
    u_ctrl.start_frame();
    u_ctrl.send_byte({OWN_ADDR, 1'b0}, a);
    u_ctrl.send_byte(8'h41, a);
    u_ctrl.start_frame();
    u_ctrl.send_byte({OWN_ADDR, 1'b1}, a);
    chk({7'h00, a}, 8'h01);
    u_ctrl.get_byte(1'b0, b);
    chk(b, 8'hA1);
    u_ctrl.get_byte(1'b1, b);
    chk(b, 8'hA2);
    chk({7'h00, sda_oe_out}, 8'h00);
    u_ctrl.stop_frame();
    chk(n_wr, 8'h03);
  endtask
  task automatic foreign_addr();
    logic a;
    u_ctrl.start_frame();
    u_ctrl.send_byte({7'h15, 1'b0}, a);
    chk({7'h00, a}, 8'h00);
    u_ctrl.send_byte(8'h00, a);
    chk({7'h00, a}, 8'h00);
    u_ctrl.stop_frame();
    chk(n_wr, 8'h03);
  endtask
  task automatic port_disabled();
    logic a;
    @(negedge sys_clk_in) iface_en_in = 1'b0;
    repeat (4) @(negedge sys_clk_in);
    u_ctrl.start_frame();
    u_ctrl.send_byte({OWN_ADDR, 1'b0}, a);
    chk({7'h00, a}, 8'h00);
    u_ctrl.stop_frame();
    @(negedge sys_clk_in) iface_en_in = 1'b1;
  endtask
  initial begin
    repeat (50_000) @(posedge sys_clk_in);
    n_mismatch++;
    close_out();
  end
  initial begin
    resetn_in      = 1'b0;
    iface_en_in    = 1'b1;
    cfg_rd_addr_in = 8'h00;
    n_mismatch     = 0;
    num_checks     = 0;
    repeat (6) @(posedge sys_clk_in);
    @(negedge sys_clk_in) resetn_in = 1'b1;
    repeat (4) @(negedge sys_clk_in);
    chk({5'h00, sda_out, sda_oe_out, busy_out}, 8'h00);
    chk({7'h00, cfg_wr_out.valid}, 8'h00);
    write_burst();
    read_burst();
    foreign_addr();
    port_disabled();
    close_out();
  end
endmodule
`default_nettype wire

// >>> verilog/icfg_consts.svh
`ifndef ICFG_CONSTS_SVH
`define ICFG_CONSTS_SVH

// ****************************************************************
// bit and byte layout of a frame
// ****************************************************************
`define ICFG_BYTE_BITS      4'h8
`define ICFG_ADDR_MSB       7
`define ICFG_ADDR_LSB       1
`define ICFG_RW_BIT         0

// ****************************************************************
// reset values
// ****************************************************************
`define ICFG_PTR_RST        8'h00
`define ICFG_BYTE_RST       8'h00
`define ICFG_CNT_RST        4'h0

// ****************************************************************
// link timing
// ****************************************************************
`define ICFG_SYS_CLK_KHZ    125000
`define ICFG_LINK_MAX_KHZ   400
`define ICFG_LINK_MIN_CYC   (`ICFG_SYS_CLK_KHZ / `ICFG_LINK_MAX_KHZ)

`endif

// >>> verilog/icfg_pkg.sv
`default_nettype none

package icfg_pkg;

  typedef enum {
    ST_IDLE,
    ST_ADDR,
    ST_ACK,
    ST_PTR,
    ST_WDATA,
    ST_RDATA,
    ST_RACK
  } icfg_state_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [7:0] data;
  } icfg_wr_t;

endpackage

`default_nettype wire

// >>> verilog/icfg_target.sv
`timescale 1ns/1ps
`default_nettype none
`include "icfg_consts.svh"

module icfg_target #(
  parameter logic [6:0] TARGET_ADDR = 7'h2A,
  parameter int         DEPTH       = 256
) (
  input  wire logic              sys_clk_in,
  input  wire logic              resetn_in,
  input  wire logic              scl_clk_in,
  input  wire logic              sda_in,
  input  wire logic              iface_en_in,
  input  wire logic [7:0]        cfg_rd_addr_in,
  output var  logic              sda_out,
  output var  logic              sda_oe_out,
  output var  icfg_pkg::icfg_wr_t cfg_wr_out,
  output var  logic [7:0]        cfg_rd_data_out,
  output var  logic              busy_out
);
  import icfg_pkg::*;

  // ****************************************************************
  // link clock domain: sample data on each rising serial clock
  // ****************************************************************
  logic link_bit;
  logic link_tgl;

  // the bit stays put until the next rising edge, microseconds away,
  // so the system side may read it once the toggle has crossed
  always_ff @(posedge scl_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      link_bit <= 1'b0;
      link_tgl <= 1'b0;
    end else begin
      link_bit <= sda_in;
      link_tgl <= ~link_tgl;
    end
  end

  // ****************************************************************
  // synchronisers into the system clock
  // ****************************************************************
  logic sda_m1, sda_s, sda_d;
  logic scl_m1, scl_s, scl_d;
  logic tgl_m1, tgl_s, tgl_d;
  logic en_m1,  en_s;

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      {sda_m1, sda_s, sda_d} <= 3'h7;
      {scl_m1, scl_s, scl_d} <= 3'h7;
      {tgl_m1, tgl_s, tgl_d} <= 3'h0;
      {en_m1, en_s}          <= 2'h0;
    end else begin
      {sda_m1, sda_s, sda_d} <= {sda_in, sda_m1, sda_s};
      {scl_m1, scl_s, scl_d} <= {scl_clk_in, scl_m1, scl_s};
      {tgl_m1, tgl_s, tgl_d} <= {link_tgl, tgl_m1, tgl_s};
      {en_m1, en_s}          <= {iface_en_in, en_m1};
    end
  end

  // ****************************************************************
  // line events
  // ****************************************************************
  wire start_ev = scl_s & scl_d & sda_d & ~sda_s & en_s;
  wire stop_ev  = scl_s & scl_d & ~sda_d & sda_s;
  wire fall_ev  = scl_d & ~scl_s;
  wire bit_ev   = tgl_s ^ tgl_d;

  // ****************************************************************
  // protocol engine
  // ****************************************************************
  icfg_state_t st, next_st;
  logic [3:0]  cnt;
  logic [7:0]  rx;
  logic [7:0]  tx;
  logic [7:0]  ptr;
  logic        rd_mode;
  logic        ack_write;
  logic        m_ack;
  logic [7:0]  mem [DEPTH];

  wire byte_done = fall_ev & (cnt == `ICFG_BYTE_BITS);
  wire addr_hit  = rx[`ICFG_ADDR_MSB:`ICFG_ADDR_LSB] == TARGET_ADDR;
  wire [7:0] rd_byte = mem[ptr];

  always_comb begin
    next_st = st;
    if (stop_ev) begin
      next_st = ST_IDLE;
    end else if (start_ev) begin
      next_st = ST_ADDR;
    end else begin
      case (st)
        ST_ADDR:  if (byte_done) next_st = addr_hit ? ST_ACK : ST_IDLE;
        ST_PTR:   if (byte_done) next_st = ST_ACK;
        ST_WDATA: if (byte_done) next_st = ST_ACK;
        ST_ACK: begin
          if (fall_ev) begin
            if (rd_mode)        next_st = ST_RDATA;
            else if (ack_write) next_st = ST_WDATA;
            else                next_st = ST_PTR;
          end
        end
        ST_RDATA: if (fall_ev && cnt == 4'h7) next_st = ST_RACK;
        ST_RACK:  if (fall_ev) next_st = m_ack ? ST_RDATA : ST_IDLE;
        default:  next_st = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st <= ST_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // bit counter and receive shift register
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt <= `ICFG_CNT_RST;
      rx  <= `ICFG_BYTE_RST;
    end else if (start_ev || (st == ST_ACK && fall_ev) || (st == ST_RACK && fall_ev)) begin
      cnt <= `ICFG_CNT_RST;
    end else if (st == ST_RDATA && fall_ev) begin
      cnt <= cnt + 4'h1;
    end else if (bit_ev && cnt < `ICFG_BYTE_BITS &&
                 (st == ST_ADDR || st == ST_PTR || st == ST_WDATA)) begin
      cnt <= cnt + 4'h1;
      rx  <= {rx[6:0], link_bit};
    end
  end

  // mode flags, pointer, master acknowledge
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_mode   <= 1'b0;
      ack_write <= 1'b0;
      m_ack     <= 1'b0;
      ptr       <= `ICFG_PTR_RST;
    end else begin
      if (st == ST_ADDR && byte_done) begin
        rd_mode   <= rx[`ICFG_RW_BIT];
        ack_write <= 1'b0;
      end
      if (st == ST_PTR && byte_done) begin
        ptr       <= rx;
        ack_write <= 1'b1;
      end
      if (st == ST_WDATA && byte_done) ptr <= ptr + 8'h01;
      if ((st == ST_ACK && rd_mode && fall_ev) ||
          (st == ST_RACK && fall_ev && m_ack)) ptr <= ptr + 8'h01;
      if (st == ST_RACK && bit_ev) m_ack <= ~link_bit;
    end
  end

  // configuration storage; no reset, contents are whatever was written
  always_ff @(posedge sys_clk_in) begin
    if (st == ST_WDATA && byte_done) mem[ptr] <= rx;
    cfg_rd_data_out <= mem[cfg_rd_addr_in];
  end

  // ****************************************************************
  // data line drive, changed after a clock fall, or released at a start or stop
  // ****************************************************************
  wire load_tx = fall_ev && ((st == ST_ACK && rd_mode) || (st == ST_RACK && m_ack));

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sda_oe_out <= 1'b0;
      sda_out    <= 1'b0;
      tx         <= `ICFG_BYTE_RST;
      busy_out   <= 1'b0;
      cfg_wr_out <= '0;
    end else begin
      sda_out    <= 1'b0;
      busy_out   <= (st != ST_IDLE) && (st != ST_ADDR);
      cfg_wr_out <= '{valid: st == ST_WDATA && byte_done, addr: ptr, data: rx};
      if (start_ev || stop_ev) begin
        sda_oe_out <= 1'b0;
      end else if (load_tx) begin
        tx         <= rd_byte;
        sda_oe_out <= ~rd_byte[7];
      end else if (fall_ev) begin
        case (st)
          ST_ADDR:  sda_oe_out <= byte_done & addr_hit;
          ST_PTR:   sda_oe_out <= byte_done;
          ST_WDATA: sda_oe_out <= byte_done;
          ST_RDATA: begin
            tx         <= {tx[6:0], 1'b0};
            sda_oe_out <= (cnt == 4'h7) ? 1'b0 : ~tx[6];
          end
          default:  sda_oe_out <= 1'b0;
        endcase
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence seq_own_addr;
    st == ST_ADDR && byte_done && addr_hit;
  endsequence

  sequence seq_data_byte;
    st == ST_WDATA && byte_done;
  endsequence

  ack_drive_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    seq_own_addr |=> sda_oe_out && st == ST_ACK)
    else $error("own address not acknowledged");

  ack_release_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (st == ST_ACK && fall_ev && !rd_mode) |=> !sda_oe_out)
    else $error("write acknowledge not released");

  foreign_quiet_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (st == ST_ADDR && byte_done && !addr_hit && !stop_ev && !start_ev) |=> st == ST_IDLE && !sda_oe_out)
    else $error("foreign address answered");

  ptr_step_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    seq_data_byte |=> cfg_wr_out.valid && ptr == $past(ptr) + 8'h01)
    else $error("write pointer did not advance");

  start_open_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (start_ev && !stop_ev) |=> st == ST_ADDR && cnt == 4'h0)
    else $error("start did not open a frame");

  stop_free_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    stop_ev |=> st == ST_IDLE && !sda_oe_out)
    else $error("stop did not release");

  drive_low_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    $changed(sda_oe_out) |-> !scl_d)
    else $error("data line moved while clock high");

  read_msb_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    load_tx && !start_ev && !stop_ev |=> sda_oe_out == !tx[7] && st == ST_RDATA)
    else $error("read byte not started msb first");

  idle_en_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (st == ST_IDLE && !en_s) |=> st == ST_IDLE)
    else $error("frame opened while port disabled");

endmodule

`default_nettype wire
